// ### logic/swm_pkg.sv
// shared constants for the switch monitor serial link
package swm_pkg;
   // frame layout
   localparam int FRAME_BITS = 32;
   localparam int ADDR_BITS = 6;
   localparam int DATA_BITS = 24;
   localparam int FLAG_BITS = 7;
   localparam int RW_POS = 31;
   localparam int ADDR_MSB = 30;
   localparam int ADDR_LSB = 25;
   localparam int DATA_MSB = 24;
   localparam int DATA_LSB = 1;
   localparam int ADDR_DONE_BITS = 7;
   // device register map
   localparam logic [5:0] INT_STAT_ADDR = 6'h01;
   localparam logic [5:0] CFG_FIRST = 6'h1A;
   localparam int CFG_COUNT = 6;
   localparam logic [5:0] TEST_ADDR = 6'h30;
   localparam logic [23:0] CFG_RESET = 24'h000000;
   localparam logic [23:0] INT_RESET = 24'h000000;
   // interrupt status bit positions
   localparam int SPI_FAIL_BIT = 0;
   localparam int PAR_FAIL_BIT = 1;
   localparam int EVT_LSB = 2;
   localparam int EVT_COUNT = 5;
   // serial clock timing
   localparam int SYS_CLK_KHZ = 25000;
   localparam int SCLK_MAX_KHZ = 4000;
   localparam int SCLK_HALF =
      (SYS_CLK_KHZ + 2 * SCLK_MAX_KHZ - 1) / (2 * SCLK_MAX_KHZ);
   // host register map (byte addresses)
   localparam logic [7:0] H_CTRL_ADDR = 8'h00;
   localparam logic [7:0] H_TX_ADDR = 8'h04;
   localparam logic [7:0] H_RX_ADDR = 8'h08;
   localparam logic [7:0] H_STAT_ADDR = 8'h0C;
   localparam int CTRL_LEN_LSB = 0;
   localparam int CTRL_LEN_W = 6;
   localparam int CTRL_GO_BIT = 8;
   localparam int CTRL_FLIP_BIT = 9;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_DONE_BIT = 1;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : swm_pkg

// ### logic/swm_if.sv
// serial link between host controller and switch monitor target
`timescale 1ns/1ps
`default_nettype none
interface swm_if;
   logic cs_n; // chip select, low selects
   logic sclk; // serial clock from host
   logic si; // host to target data
   logic so; // target output value
   logic so_oe; // target drives so
   logic so_line; // resolved level, idle line reads high
   assign so_line = so_oe ? so : 1'b1;
   modport device (input cs_n, input sclk, input si, output so,
      output so_oe);
   modport host (output cs_n, output sclk, output si, input so_line);
endinterface : swm_if
`default_nettype wire

// ### logic/swm_sync.sv
// two flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module swm_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic [WIDTH-1:0] d_in,
   output logic [WIDTH-1:0] d_out
);
   logic [WIDTH-1:0] meta_q; // first stage, read only by d_out

   // plain two stage chain, no logic between stages
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         meta_q <= RESET_VAL;
         d_out <= RESET_VAL;
      end
      else
      begin
         meta_q <= d_in;
         d_out <= meta_q;
      end
   end
endmodule : swm_sync
`default_nettype wire

// ### logic/swm_target.sv
// switch monitor serial target: frame engine and register file
`timescale 1ns/1ps
`default_nettype none
module swm_target #(
   parameter int CFG_N = swm_pkg::CFG_COUNT,
   parameter logic [23:0] TEST_VALUE = 24'h5A3C96 // arbitrary content
) (
   input wire logic sys_clk,
   input wire logic reset,
   swm_if.device link,
   input wire logic [swm_pkg::EVT_COUNT-1:0] int_event,
   output logic [CFG_N-1:0][swm_pkg::DATA_BITS-1:0] cfg_word,
   output logic [swm_pkg::DATA_BITS-1:0] int_stat,
   output logic int_n
);
   localparam int DW = swm_pkg::DATA_BITS;
   localparam int FB = swm_pkg::FRAME_BITS;

   // refuse maps that leave the 6 bit address space
   if (CFG_N < 1 || int'(swm_pkg::CFG_FIRST) + CFG_N > 64)
   begin : g_bad_cfg
      $error("swm_target: CFG_N does not fit the address space");
   end

   logic [2:0] pins_s; // synchronised cs_n, sclk, si
   logic cs_prev_q; // last synchronised select
   logic sclk_prev_q; // last synchronised clock
   logic [FB-1:0] rx_q; // input shifter
   logic [5:0] fcnt_q; // falling edges seen, saturating
   logic [4:0] ocnt_q; // rising edges seen
   logic [DW-1:0] snap_q; // status snapshot for this frame
   logic [DW-1:0] data_q; // value returned in data field
   logic so_q; // output bit
   logic so_oe_q; // output enable
   logic [DW-1:0] int_q; // interrupt status register
   logic [DW-1:0] int_d;
   logic int_n_q;
   logic [CFG_N-1:0][DW-1:0] cfg_q; // writable configuration

   // all three link pins cross into sys_clk here
   swm_sync #(
      .WIDTH(3),
      .RESET_VAL(3'b100)
   ) u_sync (
      .sys_clk(sys_clk),
      .reset(reset),
      .d_in({link.cs_n, link.sclk, link.si}),
      .d_out(pins_s)
   );

   wire cs_s = pins_s[2];
   wire sclk_s = pins_s[1];
   wire si_s = pins_s[0];
   wire cs_fall = cs_prev_q & ~cs_s;
   wire cs_rise = ~cs_prev_q & cs_s;
   // edges count only while selected
   wire sck_rise = ~cs_s & ~sclk_prev_q & sclk_s;
   wire sck_fall = ~cs_s & sclk_prev_q & ~sclk_s;

   // incoming shift, msb arrives first
   wire [FB-1:0] rx_next = {rx_q[FB-2:0], si_s};

   // address decode at the moment bit 25 lands
   wire addr_done = sck_fall &&
      (fcnt_q == 6'(swm_pkg::ADDR_DONE_BITS - 1));
   wire [5:0] rd_addr = rx_next[5:0];
   wire [5:0] rd_off = rd_addr - swm_pkg::CFG_FIRST;
   wire rd_is_cfg = (rd_addr >= swm_pkg::CFG_FIRST) &&
      (int'(rd_off) < CFG_N);
   wire rd_is_int = rd_addr == swm_pkg::INT_STAT_ADDR;
   wire rd_is_test = rd_addr == swm_pkg::TEST_ADDR;
   // unused addresses answer zero, test register its content
   wire [DW-1:0] rd_val =
      rd_is_cfg ? cfg_q[rd_off] :
      rd_is_int ? snap_q :
      rd_is_test ? TEST_VALUE : '0;

   // outgoing word: flags, data, parity making ones odd
   wire [FB-2:0] tx_body = {snap_q[swm_pkg::FLAG_BITS-1:0], data_q};
   wire [FB-1:0] tx_word = {tx_body, ~^tx_body};

   // frame end checks use the finished shifter
   wire [5:0] wr_addr = rx_q[swm_pkg::ADDR_MSB:swm_pkg::ADDR_LSB];
   wire [5:0] wr_off = wr_addr - swm_pkg::CFG_FIRST;
   wire wr_is_cfg = (wr_addr >= swm_pkg::CFG_FIRST) &&
      (int'(wr_off) < CFG_N);
   wire is_write = rx_q[swm_pkg::RW_POS];
   wire used = fcnt_q != 6'h00;
   wire len_ok = fcnt_q == 6'(FB);
   wire par_ok = ^rx_q;
   wire good = cs_rise & len_ok & par_ok;
   wire len_err = cs_rise & used & ~len_ok;
   wire par_err = cs_rise & len_ok & ~par_ok;
   wire commit = good & is_write & wr_is_cfg;
   // only bits shown in this frame are cleared, so later events stay
   wire int_clr = good & ~is_write &
      (wr_addr == swm_pkg::INT_STAT_ADDR);

   // status update, a set in the clearing cycle wins
   always_comb
   begin
      int_d = int_q & ~(int_clr ? snap_q : '0);
      int_d[swm_pkg::SPI_FAIL_BIT] =
         int_d[swm_pkg::SPI_FAIL_BIT] | len_err;
      int_d[swm_pkg::PAR_FAIL_BIT] =
         int_d[swm_pkg::PAR_FAIL_BIT] | par_err;
      int_d[swm_pkg::EVT_LSB +: swm_pkg::EVT_COUNT] =
         int_d[swm_pkg::EVT_LSB +: swm_pkg::EVT_COUNT] | int_event;
   end

   // edge history of synchronised pins
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         cs_prev_q <= 1'b1;
         sclk_prev_q <= 1'b0;
      end
      else
      begin
         cs_prev_q <= cs_s;
         sclk_prev_q <= sclk_s;
      end
   end

   // receive side: restart at select fall, shift on clock fall
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         rx_q <= '0;
         fcnt_q <= '0;
      end
      else if (cs_fall)
      begin
         rx_q <= '0;
         fcnt_q <= '0;
      end
      else if (sck_fall)
      begin
         rx_q <= rx_next;
         // saturate so long frames still read as wrong length
         if (fcnt_q != 6'h3F)
         begin
            fcnt_q <= fcnt_q + 6'h01;
         end
      end
   end

   // snapshot and old value capture
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         snap_q <= swm_pkg::INT_RESET;
         data_q <= '0;
      end
      else if (cs_fall)
      begin
         snap_q <= int_q;
         data_q <= '0;
      end
      else if (addr_done)
      begin
         data_q <= rd_val;
      end
   end

   // transmit side: high on select, next bit on each clock rise
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         so_q <= 1'b1;
         so_oe_q <= 1'b0;
         ocnt_q <= '0;
      end
      else if (cs_fall)
      begin
         so_q <= 1'b1;
         so_oe_q <= 1'b1;
         ocnt_q <= '0;
      end
      else if (cs_rise || cs_s)
      begin
         so_oe_q <= 1'b0;
      end
      else if (sck_rise)
      begin
         // index 31 minus count, bit 31 first
         so_q <= tx_word[~ocnt_q];
         ocnt_q <= ocnt_q + 5'h01;
      end
   end

   // status register and interrupt line
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         int_q <= swm_pkg::INT_RESET;
         int_n_q <= 1'b1;
      end
      else
      begin
         int_q <= int_d;
         int_n_q <= ~|int_d;
      end
   end

   // one configuration word per entry, written only on commit
   for (genvar i = 0; i < CFG_N; i++)
   begin : g_cfg
      always_ff @(posedge sys_clk)
      begin
         if (reset)
         begin
            cfg_q[i] <= swm_pkg::CFG_RESET;
         end
         else if (commit && int'(wr_off) == i)
         begin
            cfg_q[i] <= rx_q[swm_pkg::DATA_MSB:swm_pkg::DATA_LSB];
         end
      end
   end

   assign link.so = so_q;
   assign link.so_oe = so_oe_q;
   assign cfg_word = cfg_q;
   assign int_stat = int_q;
   assign int_n = int_n_q;
endmodule : swm_target
`default_nettype wire

// ### logic/swm_host.sv
// host controller: AXI4-Lite registers driving serial frames
`timescale 1ns/1ps
`default_nettype none
module swm_host #(
   parameter int HALF = swm_pkg::SCLK_HALF
) (
   input wire logic sys_clk,
   input wire logic reset,
   swm_if.host link,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   // a shorter half period would break the clock limit
   if (HALF < swm_pkg::SCLK_HALF || HALF > 255)
   begin : g_bad_half
      $error("swm_host: HALF out of range");
   end

   typedef enum {H_IDLE, H_LEAD, H_HIGH, H_LOW, H_TAIL, H_GAP}
      swm_state_type;
   swm_state_type st_q;
   logic [7:0] tmr_q; // half period timer
   logic [5:0] left_q; // bits still to clock
   logic [31:0] sh_q; // outgoing shifter
   logic [31:0] rx_q; // received word
   logic [31:0] tx_q; // command word, bit0 replaced by parity
   localparam int CTRL_W = swm_pkg::CTRL_FLIP_BIT + 1;
   logic [CTRL_W-1:0] ctrl_q; // length, go and parity flip as written
   logic done_q, cs_n_q, sclk_q, si_q, so_s;
   logic aw_q, w_q, bv_q, rv_q;
   logic [7:0] awa_q;
   logic [31:0] wd_q, rd_q;
   logic [1:0] br_q, rr_q;

   swm_sync #(
      .WIDTH(1),
      .RESET_VAL(1'b1)
   ) u_so_sync (
      .sys_clk(sys_clk),
      .reset(reset),
      .d_in(link.so_line),
      .d_out(so_s)
   );

   wire tick = tmr_q == 8'(HALF - 1);
   wire busy = st_q != H_IDLE;
   wire do_wr = aw_q & w_q & ~bv_q;
   wire wr_ctrl = do_wr && awa_q == swm_pkg::H_CTRL_ADDR;
   wire wr_tx = do_wr && awa_q == swm_pkg::H_TX_ADDR;
   wire wr_ok = wr_ctrl | wr_tx;
   wire go = wr_ctrl & ~busy & wd_q[swm_pkg::CTRL_GO_BIT];
   // odd parity over bits 31..1, optional flip for error tests
   wire par = ~^tx_q[31:1] ^ wd_q[swm_pkg::CTRL_FLIP_BIT];
   wire [31:0] frame = {tx_q[31:1], par};
   wire [31:0] stat = {30'h0, done_q, busy};
   wire [31:0] rd_mux =
      s_axi_araddr == swm_pkg::H_CTRL_ADDR ? 32'(ctrl_q) :
      s_axi_araddr == swm_pkg::H_TX_ADDR ? tx_q :
      s_axi_araddr == swm_pkg::H_RX_ADDR ? rx_q :
      s_axi_araddr == swm_pkg::H_STAT_ADDR ? stat : 32'h0;
   wire rd_hit = s_axi_araddr[7:4] == 4'h0 && s_axi_araddr[1:0] == 2'h0;

   // write channels held independently, answer after both
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         aw_q <= 1'b0;
         w_q <= 1'b0;
         bv_q <= 1'b0;
         awa_q <= '0;
         wd_q <= '0;
         br_q <= swm_pkg::RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_q <= 1'b1;
            awa_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_q <= 1'b1;
            for (int b = 0; b < 4; b++)
               wd_q[8*b +: 8] <= s_axi_wstrb[b] ?
                  s_axi_wdata[8*b +: 8] : 8'h00;
         end
         if (do_wr)
         begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            bv_q <= 1'b1;
            br_q <= wr_ok ? swm_pkg::RESP_OKAY : swm_pkg::RESP_SLVERR;
         end
         else if (bv_q && s_axi_bready)
         begin
            bv_q <= 1'b0;
         end
      end
   end

   // read channel, one outstanding
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         rv_q <= 1'b0;
         rd_q <= '0;
         rr_q <= swm_pkg::RESP_OKAY;
      end
      else if (s_axi_arvalid && !rv_q)
      begin
         rv_q <= 1'b1;
         rd_q <= rd_hit ? rd_mux : 32'h0;
         rr_q <= rd_hit ? swm_pkg::RESP_OKAY : swm_pkg::RESP_SLVERR;
      end
      else if (rv_q && s_axi_rready)
      begin
         rv_q <= 1'b0;
      end
   end

   // command registers; tx ignored while a frame runs
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         tx_q <= '0;
         ctrl_q <= '0;
      end
      else
      begin
         if (wr_tx && !busy)
            tx_q <= wd_q;
         if (wr_ctrl && !busy)
            ctrl_q <= wd_q[CTRL_W-1:0];
      end
   end

   // frame sequencer; select moves only with clock low
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         st_q <= H_IDLE;
         tmr_q <= '0;
         left_q <= '0;
         sh_q <= '0;
         rx_q <= '0;
         done_q <= 1'b0;
         cs_n_q <= 1'b1;
         sclk_q <= 1'b0;
         si_q <= 1'b0;
      end
      else
      begin
         tmr_q <= (busy && !tick) ? tmr_q + 8'h01 : 8'h00;
         unique case (st_q)
            H_IDLE:
               if (go)
               begin
                  cs_n_q <= 1'b0;
                  sh_q <= frame;
                  si_q <= frame[31];
                  left_q <= wd_q[swm_pkg::CTRL_LEN_LSB +: swm_pkg::CTRL_LEN_W];
                  done_q <= 1'b0;
                  st_q <= H_LEAD;
               end
            H_LEAD:
               if (tick)
               begin
                  sclk_q <= left_q != 6'h00;
                  st_q <= left_q != 6'h00 ? H_HIGH : H_TAIL;
               end
            H_HIGH:
               if (tick)
               begin
                  sclk_q <= 1'b0;
                  st_q <= H_LOW;
               end
            H_LOW:
               // sample late in the low phase, after the fall
               if (tick)
               begin
                  rx_q <= {rx_q[30:0], so_s};
                  sh_q <= {sh_q[30:0], 1'b0};
                  // last bit stays put: data only moves with a clock rise
                  si_q <= left_q != 6'h01 ? sh_q[30] : si_q;
                  left_q <= left_q - 6'h01;
                  sclk_q <= left_q != 6'h01;
                  st_q <= left_q != 6'h01 ? H_HIGH : H_TAIL;
               end
            H_TAIL:
               if (tick)
               begin
                  cs_n_q <= 1'b1;
                  st_q <= H_GAP;
               end
            H_GAP:
               if (tick)
               begin
                  done_q <= 1'b1;
                  st_q <= H_IDLE;
               end
         endcase
      end
   end

   assign link.cs_n = cs_n_q;
   assign link.sclk = sclk_q;
   assign link.si = si_q;
   assign s_axi_awready = ~aw_q & ~bv_q;
   assign s_axi_wready = ~w_q & ~bv_q;
   assign s_axi_bvalid = bv_q;
   assign s_axi_bresp = br_q;
   assign s_axi_arready = ~rv_q;
   assign s_axi_rvalid = rv_q;
   assign s_axi_rdata = rd_q;
   assign s_axi_rresp = rr_q;
endmodule : swm_host
`default_nettype wire

// ### dv/swm_link_sva.sv
// link checker for the host and target serial frames
`timescale 1ns/1ps
`default_nettype none
module swm_link_sva (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic si,
   input wire logic so,
   input wire logic so_oe,
   input wire logic so_line
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (reset);
   // selection opens: select pin falls
   sequence sel_open;
      $fell(cs_n);
   endsequence
   // selection closes: select pin rises
   sequence sel_close;
      $rose(cs_n);
   endsequence
   // target drives a high line soon after selection
   drive_on_a: assert property (sel_open |-> ##[1:4] (so_oe && so))
      else $error("output not driven high after select fall");
   // target lets go of the line after deselection
   drive_off_a: assert property (sel_close |-> ##[1:6] !so_oe)
      else $error("output still driven after select rise");
   // long deselection keeps the line released and idle high
   idle_off_a: assert property (cs_n [*6] |-> !so_oe && so_line)
      else $error("output driven while deselected");
   // select moves only while the serial clock rests low
   clean_select_a: assert property (
      $changed(cs_n) |-> !sclk && !$past(sclk))
      else $error("select moved with serial clock high");
   // lead time before the first clock rise
   lead_time_a: assert property (sel_open |-> (!sclk) [*4])
      else $error("serial clock rose too soon after select");
   // half periods of at least four system clocks keep below 4 MHz
   clock_high_a: assert property ($rose(sclk) |-> sclk [*4])
      else $error("serial clock high phase too short");
   clock_low_a: assert property (
      $fell(sclk) && !cs_n |-> (!sclk) [*4])
      else $error("serial clock low phase too short");
   // input data moves only at a clock rise or at selection
   si_hold_a: assert property (
      !cs_n && $changed(si) |-> $rose(sclk) || $fell(cs_n))
      else $error("input data moved away from a clock rise");
   // output data moves only in the wake of a clock rise
   so_shift_a: assert property (so_oe && $past(so_oe, 2) && $changed(so)
      |-> sclk || $past(sclk))
      else $error("output data moved outside a clock high phase");
endmodule : swm_link_sva
`default_nettype wire

// ### dv/switch_monitor_spi_target_tb.sv
// self-checking bench: host and target joined over the serial link
`timescale 1ns/1ps
`default_nettype none
module switch_monitor_spi_target_tb;
   logic sys_clk = 1'b0; // 25 MHz
   logic reset = 1'b1; // synchronous, active high
   logic [7:0] awaddr = 8'h00;
   logic awvalid = 1'b0;
   logic awready;
   logic [31:0] wdata = 32'h0;
   logic wvalid = 1'b0;
   logic wready;
   logic [1:0] bresp;
   logic bvalid;
   logic bready = 1'b0;
   logic [7:0] araddr = 8'h00;
   logic arvalid = 1'b0;
   logic arready;
   logic [31:0] rdata;
   logic [1:0] rresp;
   logic rvalid;
   logic rready = 1'b0;
   logic [4:0] int_event = 5'h00; // switch events into the target
   logic [5:0][23:0] cfg_word;
   logic [23:0] int_stat;
   logic int_n;
   int failures = 0;
   int n_tests = 0;
   int mon_cnt = 0; // falling clock edges seen in the frame
   logic [31:0] si_sh = 32'h0; // input bits seen on the wire
   logic sclk_p = 1'b0;
   logic cs_p = 1'b1;
   logic [31:0] rx;
   logic [31:0] rd;
   logic [1:0] resp;
   swm_if swm_if_i ();
   swm_host swm_host_i (.sys_clk(sys_clk), .reset(reset), .link(swm_if_i),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready));
   swm_target swm_target_i (.sys_clk(sys_clk), .reset(reset),
      .link(swm_if_i), .int_event(int_event), .cfg_word(cfg_word),
      .int_stat(int_stat), .int_n(int_n));
   swm_link_sva swm_link_sva_i (.sys_clk(sys_clk), .reset(reset),
      .cs_n(swm_if_i.cs_n), .sclk(swm_if_i.sclk), .si(swm_if_i.si),
      .so(swm_if_i.so), .so_oe(swm_if_i.so_oe), .so_line(swm_if_i.so_line));
   initial forever #20 sys_clk = ~sys_clk;
   // wire monitor: counts falls, gathers input bits msb first
   always @(posedge sys_clk)
   begin
      sclk_p <= swm_if_i.sclk;
      cs_p <= swm_if_i.cs_n;
      if (cs_p && !swm_if_i.cs_n)
         mon_cnt <= 0;
      else if (!swm_if_i.cs_n && sclk_p && !swm_if_i.sclk)
      begin
         mon_cnt <= mon_cnt + 1;
         si_sh <= {si_sh[30:0], swm_if_i.si};
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         failures++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen,
            exp);
      end
   endtask : check
   task automatic wrap_up();
      $display("%0d comparisons, %0d mismatches", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : wrap_up
   // odd parity in bit 0 over bits 31 to 1
   function automatic logic [31:0] pw(input logic [31:0] x);
      return {x[31:1], ~^x[31:1]};
   endfunction : pw
   // one write; address and data offered together, released when taken
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
      output logic [1:0] r);
      bit aw_ok = 1'b0;
      bit w_ok = 1'b0;
      @(posedge sys_clk);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= d;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(aw_ok && w_ok))
      begin
         @(posedge sys_clk);
         if (!aw_ok && awready === 1'b1)
         begin
            aw_ok = 1'b1;
            awvalid <= 1'b0;
         end
         if (!w_ok && wready === 1'b1)
         begin
            w_ok = 1'b1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge sys_clk); while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
   endtask : axi_wr
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
      output logic [1:0] r);
      @(posedge sys_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge sys_clk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge sys_clk); while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask : axi_rd
   // one frame of len bits, parity optionally spoilt, wire checked
   task automatic xfer(input logic [5:0] len, input logic flip,
      input logic [31:0] w, output logic [31:0] rxw);
      logic [31:0] st;
      logic [1:0] r;
      axi_wr(swm_pkg::H_TX_ADDR, w, r);
      axi_wr(swm_pkg::H_CTRL_ADDR, {22'h0, flip, 1'b1, 2'h0, len}, r);
      do axi_rd(swm_pkg::H_STAT_ADDR, st, r); while (st[1] !== 1'b1);
      axi_rd(swm_pkg::H_RX_ADDR, rxw, r);
      check(32'(mon_cnt), {26'h0, len});
      if (len == 6'h20 && !flip)
         check(si_sh, pw(w));
      check({31'h0, swm_if_i.so_line}, 32'h1);
   endtask : xfer
   task automatic dev_rd(input logic [5:0] a, input logic [23:0] exp,
      input logic [6:0] fl);
      xfer(6'h20, 1'b0, {1'b0, a, 25'h0}, rx);
      check(rx, pw({fl, exp, 1'b0}));
   endtask : dev_rd
   task automatic dev_wr(input logic [5:0] a, input logic [23:0] d,
      input logic [23:0] old, input logic [6:0] fl);
      xfer(6'h20, 1'b0, {1'b1, a, d, 1'b0}, rx);
      check(rx, pw({fl, old, 1'b0}));
   endtask : dev_wr
   // timeout well past the expected run of some five thousand cycles
   initial
   begin
      repeat (60000) @(posedge sys_clk);
      failures++;
      $display("watchdog expired");
      wrap_up();
   end
   initial
   begin
      repeat (20) @(posedge sys_clk);
      reset <= 1'b0;
      @(posedge sys_clk);
      check({8'h0, int_stat}, 32'h0);
      check({31'h0, int_n}, 32'h1);
      // host refuses unmapped places, one write and one read
      axi_wr(8'h20, 32'h0, resp);
      check({30'h0, resp}, {30'h0, swm_pkg::RESP_SLVERR});
      axi_rd(8'h10, rd, resp);
      check(rd, 32'h0);
      check({30'h0, resp}, {30'h0, swm_pkg::RESP_SLVERR});
      $display("test bus_refusal done");
      // every config word, frames back to back
      for (int i = 0; i < swm_pkg::CFG_COUNT; i++)
      begin
         dev_wr(swm_pkg::CFG_FIRST + 6'(i), {4'hA, 20'(i)},
            24'h0, 7'h0);
         check({8'h0, cfg_word[i]}, {8'h0, 24'hA00000 + 24'(i)});
      end
      dev_wr(swm_pkg::CFG_FIRST, 24'h5A5A5A, 24'hA00000, 7'h0);
      dev_rd(swm_pkg::CFG_FIRST + 6'h5, 24'hA00005, 7'h0);
      $display("test config done");
      // test register and unused places
      dev_rd(swm_pkg::TEST_ADDR, 24'h5A3C96, 7'h0);
      dev_wr(swm_pkg::TEST_ADDR, 24'h123456, 24'h5A3C96, 7'h0);
      dev_rd(swm_pkg::TEST_ADDR, 24'h5A3C96, 7'h0);
      dev_rd(6'h02, 24'h0, 7'h0);
      dev_wr(6'h05, 24'hFFFFFF, 24'h0, 7'h0);
      check({8'h0, cfg_word[1]}, 32'h00A00001);
      $display("test special_places done");
      // event, then empty, bad parity and short frames
      @(posedge sys_clk);
      int_event <= 5'h04;
      @(posedge sys_clk);
      int_event <= 5'h00;
      xfer(6'h00, 1'b0, 32'h0, rx);
      check({8'h0, int_stat}, 32'h10);
      xfer(6'h20, 1'b1, {1'b1, swm_pkg::CFG_FIRST, 24'h777777, 1'b0}, rx);
      check({8'h0, cfg_word[0]}, 32'h005A5A5A);
      check({8'h0, int_stat}, 32'h12);
      xfer(6'h1F, 1'b0, 32'h0, rx);
      check({8'h0, int_stat}, 32'h13);
      check({31'h0, int_n}, 32'h0);
      dev_rd(swm_pkg::INT_STAT_ADDR, 24'h13, 7'h13);
      check({8'h0, int_stat}, 32'h0);
      check({31'h0, int_n}, 32'h1);
      // long frame
      xfer(6'h21, 1'b0, 32'hFFFFFFFF, rx);
      check({8'h0, int_stat}, 32'h1);
      dev_rd(swm_pkg::INT_STAT_ADDR, 24'h1, 7'h01);
      $display("test errors done");
      wrap_up();
   end
endmodule : switch_monitor_spi_target_tb
`default_nettype wire
